// *** hall_conversion_and_fault_flags.sv ***
// conversion sequencer, limit alerting and latched fault flags of a 3-axis hall sensor
`timescale 1ns/1ns
`default_nettype none
module hall_conversion_and_fault_flags
  import hall_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        alert_in,
  output logic             alert_out,
  output logic             alert_oe_n,
  input  wire logic [15:0] adc_code,
  output logic             spin_active,
  output logic      [1:0]  spin_axis,
  output logic             adc_active,
  output logic      [1:0]  adc_axis,
  input  wire logic        supply_low_event,
  input  wire logic        otp_crc_mismatch,
  input  wire logic        clock_fault
);

  // channel list: four {valid, channel} entries, temperature always first
  function automatic logic [11:0] build_list(input logic [3:0] sel);
    logic [11:0] l;
    int n;
    l = 12'h000;
    n = 1;
    l[2:0] = {1'b1, CH_TEMP};
    if (sel == SEQ_XZX) begin
      l = {1'b1, CH_X, 1'b1, CH_Z, 1'b1, CH_X, 1'b1, CH_TEMP};
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (sel[i]) begin
          l[n*3 +: 3] = {1'b1, 2'(i + 1)};
          n++;
        end
      end
    end
    return l;
  endfunction

  function automatic logic has_chan(input logic [11:0] l, input logic [1:0] ch);
    logic hit;
    hit = 1'b0;
    for (int i = 1; i < 4; i++) begin
      if (l[i*3+2] && (l[i*3 +: 2] == ch)) hit = 1'b1;
    end
    return hit;
  endfunction

  // drift gain from temperature delta, applied multiplicatively to the raw code
  function automatic logic [15:0] thermal_fix(input logic [15:0] raw, input logic [15:0] temp,
                                              input logic [7:0] coef);
    logic signed [16:0] delta;
    logic signed [25:0] prod;
    logic signed [15:0] gain;
    logic signed [31:0] adj;
    delta = $signed({1'b0, temp}) - $signed({1'b0, TEMP_REF});
    prod  = delta * $signed({1'b0, coef});
    gain  = prod[GAIN_SHIFT +: 16];
    adj   = $signed(raw) * gain;
    return 16'($signed(raw) + $signed(adj[ADJ_SHIFT +: 16]));
  endfunction

  // four crossing conditions; band codes below the minimum mean a single threshold
  function automatic logic limit_hit(input logic [15:0] v, input logic [15:0] upper,
                                     input logic [15:0] lower, input logic band,
                                     input logic dir);
    logic above;
    logic below;
    above = $signed(v) > $signed(upper);
    below = $signed(v) < $signed(lower);
    if (!band) return dir ? ($signed(v) < $signed(upper)) : above;
    return dir ? (!above && !below) : (above || below);
  endfunction

  logic [7:0]  ctrl_q, axis_q, thr_q, rdata_q;
  logic [3:0]  sync1_q, sync2_q;
  logic        alert_prev_q;
  logic        seq_q, check_q, ready_q, por_q, x_seen_q;
  logic [11:0] list_q;
  logic [2:0]  avg_n_q, set_count_q;
  logic [7:0]  coef_q;
  logic        s1_busy_q, s2_busy_q, s2_first_q, s2_last_q, s2_final_q;
  logic [8:0]  s1_cnt_q, s2_cnt_q, alert_cnt_q, settle_q;
  logic [1:0]  s1_idx_q, s1_chan_q, s2_chan_q;
  logic [4:0]  s1_rep_q;
  logic [20:0] acc_q;
  logic [15:0] temp_q, x_q, y_q, z_q;
  logic [4:0]  fault_q;

  // first stage flops feed only the second stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 4'h1; // alert pin idles high; a low reset value would fake a falling edge
      sync2_q <= 4'h1;
      alert_prev_q <= 1'b1;
    end else begin
      sync1_q <= {clock_fault, otp_crc_mismatch, supply_low_event, alert_in};
      sync2_q <= sync1_q;
      alert_prev_q <= sync2_q[0];
    end
  end

  wire alert_s   = sync2_q[0];
  wire wr_ctrl   = reg_wr_en && (reg_addr == ADDR_CONV_CTRL);
  wire wr_status = reg_wr_en && (reg_addr == ADDR_CONV_STATUS);
  wire wr_fault  = reg_wr_en && (reg_addr == ADDR_FAULT_STATUS);
  wire [1:0] mode = ctrl_q[MODE_LSB +: 2];
  wire [2:0] avg_sel = ctrl_q[AVG_LSB +: 3];
  wire [1:0] drift_sel = ctrl_q[DRIFT_LSB +: 2];
  wire driving = (alert_cnt_q != 9'h000);

  // triggers: command bit or falling edge on the alert pin while we do not drive it
  wire pin_trig = !driving && alert_prev_q && !alert_s;
  wire cmd_trig = wr_ctrl && reg_wdata[TRIG_BIT];
  wire seq_start = !seq_q && ((mode == MODE_CONTINUOUS) ||
                              ((mode == MODE_TRIGGERED) && (cmd_trig || pin_trig)));

  // per-sequence settings are frozen at the start so register writes cannot tear a sequence
  wire [2:0] avg_n = (avg_sel > AVG_MAX) ? AVG_MAX : avg_sel;
  wire [7:0] mag_coef = (drift_sel == 2'h0) ? 8'h00 :
                        (drift_sel == 2'h1) ? COEF_SEL1 :
                        (drift_sel == 2'h2) ? COEF_SEL2 : COEF_SEL3;
  wire [4:0] rep_max = 5'((6'h01 << avg_n_q) - 6'h01);

  // spin stage item bookkeeping
  wire       s1_is_temp  = (s1_chan_q == CH_TEMP);
  wire       s1_last_rep = s1_is_temp || (s1_rep_q == rep_max);
  wire       next_valid  = (s1_idx_q != 2'h3) && list_q[3*(int'(s1_idx_q) + 1) + 2];
  wire [2:0] nxt_ent     = next_valid ? list_q[3*(int'(s1_idx_q) + 1) +: 3] : {1'b0, CH_TEMP};
  wire       s1_final    = s1_last_rep && !next_valid;
  wire       handoff     = s1_busy_q && (s1_cnt_q == 9'h000) && !s2_busy_q;
  wire       s2_done     = s2_busy_q && (s2_cnt_q == 9'h000);

  // sequence control and the spin/integrate stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_q <= 1'b0;
      list_q <= 12'h000;
      avg_n_q <= 3'h0;
      coef_q <= 8'h00;
      s1_busy_q <= 1'b0;
      s1_cnt_q <= 9'h000;
      s1_idx_q <= 2'h0;
      s1_rep_q <= 5'h00;
      s1_chan_q <= CH_TEMP;
    end else if (seq_start) begin
      seq_q <= 1'b1;
      list_q <= build_list(axis_q[SEQ_LSB +: 4]);
      avg_n_q <= avg_n;
      coef_q <= 8'(SENSOR_COEF + mag_coef);
      s1_busy_q <= 1'b1;
      s1_cnt_q <= 9'(SPIN_CYC - 9'h001);
      s1_idx_q <= 2'h0;
      s1_rep_q <= 5'h00;
      s1_chan_q <= CH_TEMP;
    end else begin
      if (check_q) seq_q <= 1'b0;
      if (handoff) begin
        s1_busy_q <= !s1_final;
        s1_cnt_q <= 9'(SPIN_CYC - 9'h001);
        if (s1_last_rep) begin
          s1_idx_q <= 2'(s1_idx_q + 2'h1);
          s1_rep_q <= 5'h00;
          s1_chan_q <= nxt_ent[1:0];
        end else begin
          s1_rep_q <= 5'(s1_rep_q + 5'h01);
        end
      end else if (s1_busy_q && (s1_cnt_q != 9'h000)) begin
        s1_cnt_q <= 9'(s1_cnt_q - 9'h001);
      end
    end
  end

  // adc stage takes over the item the spin stage just finished
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s2_busy_q <= 1'b0;
      s2_cnt_q <= 9'h000;
      s2_chan_q <= CH_TEMP;
      s2_first_q <= 1'b0;
      s2_last_q <= 1'b0;
      s2_final_q <= 1'b0;
    end else if (handoff) begin
      s2_busy_q <= 1'b1;
      s2_cnt_q <= 9'(ADC_CYC - 9'h001);
      s2_chan_q <= s1_chan_q;
      s2_first_q <= (s1_rep_q == 5'h00);
      s2_last_q <= s1_last_rep;
      s2_final_q <= s1_final;
    end else if (s2_done) begin
      s2_busy_q <= 1'b0;
    end else if (s2_busy_q) begin
      s2_cnt_q <= 9'(s2_cnt_q - 9'h001);
    end
  end

  // averaging and correction of the finished sample
  wire [20:0] sample_x  = {{5{adc_code[15]}}, adc_code};
  wire [20:0] acc_sum   = s2_first_q ? sample_x : 21'(acc_q + sample_x);
  wire [20:0] acc_shift = 21'($signed(acc_sum) >>> avg_n_q);
  wire [15:0] corrected = thermal_fix(acc_shift[15:0], temp_q, coef_q);
  wire [16:0] x_pair    = 17'($signed({x_q[15], x_q}) + $signed({corrected[15], corrected}));

  // result registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 21'h000000;
      temp_q <= 16'h0000;
      x_q <= 16'h0000;
      y_q <= 16'h0000;
      z_q <= 16'h0000;
      x_seen_q <= 1'b0;
    end else if (seq_start) begin
      x_seen_q <= 1'b0;
    end else if (s2_done) begin
      acc_q <= acc_sum;
      if (s2_chan_q == CH_TEMP) begin
        temp_q <= adc_code;
      end else if (s2_last_q) begin
        case (s2_chan_q)
          CH_X: begin
            x_q <= x_seen_q ? x_pair[16:1] : corrected;
            x_seen_q <= 1'b1;
          end
          CH_Y: y_q <= corrected;
          default: z_q <= corrected;
        endcase
      end
    end
  end

  // limit check one cycle after the last result lands, on every enabled axis
  wire        band_on = (axis_q[BAND_LSB +: 3] >= BAND_MIN_CODE);
  wire [15:0] band_w  = 16'(BAND_BASE << 3'(axis_q[BAND_LSB +: 3] - BAND_MIN_CODE));
  wire [15:0] upper   = {thr_q, 8'h00};
  wire [15:0] lower   = band_on ? 16'(upper - band_w) : upper;
  wire        dir     = axis_q[DIR_BIT];
  wire        hit = (has_chan(list_q, CH_X) && limit_hit(x_q, upper, lower, band_on, dir)) ||
                    (has_chan(list_q, CH_Y) && limit_hit(y_q, upper, lower, band_on, dir)) ||
                    (has_chan(list_q, CH_Z) && limit_hit(z_q, upper, lower, band_on, dir));

  // alert pulse per conversion while in region; readback watched for pin faults
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      check_q <= 1'b0;
      alert_cnt_q <= 9'h000;
      settle_q <= 9'h000;
    end else begin
      check_q <= s2_done && s2_final_q;
      if (check_q && hit) alert_cnt_q <= PULSE_CYC;
      else if (driving) alert_cnt_q <= 9'(alert_cnt_q - 9'h001);
      if (!driving) settle_q <= 9'h000;
      else if (settle_q != SETTLE_CYC) settle_q <= 9'(settle_q + 9'h001);
    end
  end

  wire       pin_fault = driving && (settle_q == SETTLE_CYC) && alert_s;
  wire [4:0] events = {1'b0, sync2_q[3], pin_fault, sync2_q[2], sync2_q[1]};
  wire [4:0] w1c = wr_fault ? reg_wdata[4:0] : 5'h00;

  // host registers; a set arriving with its clear wins, the host must acknowledge with ones
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
      axis_q <= AXIS_RESET;
      thr_q <= THR_RESET;
      fault_q <= 5'h10; // readback starts at the pulled-up pin level
      por_q <= 1'b1;
      ready_q <= 1'b0;
      set_count_q <= 3'h0;
    end else begin
      if (wr_ctrl) ctrl_q <= {1'b0, reg_wdata[6:0]}; // trigger bit never stored
      if (reg_wr_en && (reg_addr == ADDR_AXIS_CTRL)) axis_q <= reg_wdata;
      if (reg_wr_en && (reg_addr == ADDR_LIMIT_THR)) thr_q <= reg_wdata;
      fault_q[FLT_SUPPLY] <= (fault_q[FLT_SUPPLY] && !w1c[FLT_SUPPLY]) || events[FLT_SUPPLY];
      fault_q[FLT_OTP] <= (fault_q[FLT_OTP] && !w1c[FLT_OTP]) || events[FLT_OTP];
      fault_q[FLT_ALERT] <= (fault_q[FLT_ALERT] && !w1c[FLT_ALERT]) || events[FLT_ALERT];
      fault_q[FLT_CLOCK] <= (fault_q[FLT_CLOCK] && !w1c[FLT_CLOCK]) || events[FLT_CLOCK];
      fault_q[FLT_READBACK] <= alert_s;
      if (wr_status && reg_wdata[POR_BIT]) por_q <= 1'b0;
      if (check_q) begin
        ready_q <= 1'b1;
        set_count_q <= 3'(set_count_q + 3'h1);
      end else if (seq_start) begin
        ready_q <= 1'b0;
      end
    end
  end

  wire       diag = |fault_q[FLT_CLOCK:FLT_SUPPLY];
  wire [7:0] conv_status = {set_count_q, por_q, 2'h0, diag, ready_q};
  // read decode; unmapped offsets read as zero
  wire [7:0] rd_mux =
    (reg_addr == ADDR_CONV_CTRL)    ? ctrl_q :
    (reg_addr == ADDR_AXIS_CTRL)    ? axis_q :
    (reg_addr == ADDR_LIMIT_THR)    ? thr_q :
    (reg_addr == ADDR_TEMP_MSB)     ? temp_q[15:8] :
    (reg_addr == ADDR_TEMP_LSB)     ? temp_q[7:0] :
    (reg_addr == ADDR_X_MSB)        ? x_q[15:8] :
    (reg_addr == ADDR_X_LSB)        ? x_q[7:0] :
    (reg_addr == ADDR_Y_MSB)        ? y_q[15:8] :
    (reg_addr == ADDR_Y_LSB)        ? y_q[7:0] :
    (reg_addr == ADDR_Z_MSB)        ? z_q[15:8] :
    (reg_addr == ADDR_Z_LSB)        ? z_q[7:0] :
    (reg_addr == ADDR_CONV_STATUS)  ? conv_status :
    (reg_addr == ADDR_FAULT_STATUS) ? {3'h0, fault_q} : 8'h00;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) rdata_q <= 8'h00;
    else if (reg_rd_en) rdata_q <= rd_mux;
  end

  assign reg_rdata   = rdata_q;
  assign alert_out   = 1'b0;       // open drain: only ever pulls low
  assign alert_oe_n  = !driving;
  assign spin_active = s1_busy_q;
  assign spin_axis   = s1_chan_q;
  assign adc_active  = s2_busy_q;
  assign adc_axis    = s2_chan_q;
endmodule
`default_nettype wire

// *** hall_pkg.sv ***
// constants for the hall conversion sequencer, limit checker and fault flags
package hall_pkg;
  // register offsets
  localparam logic [7:0] ADDR_CONV_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_AXIS_CTRL    = 8'h01;
  localparam logic [7:0] ADDR_LIMIT_THR    = 8'h02;
  localparam logic [7:0] ADDR_TEMP_MSB     = 8'h10;
  localparam logic [7:0] ADDR_TEMP_LSB     = 8'h11;
  localparam logic [7:0] ADDR_X_MSB        = 8'h12;
  localparam logic [7:0] ADDR_X_LSB        = 8'h13;
  localparam logic [7:0] ADDR_Y_MSB        = 8'h14;
  localparam logic [7:0] ADDR_Y_LSB        = 8'h15;
  localparam logic [7:0] ADDR_Z_MSB        = 8'h16;
  localparam logic [7:0] ADDR_Z_LSB        = 8'h17;
  localparam logic [7:0] ADDR_CONV_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h1C;

  // conv_ctrl fields
  localparam int MODE_LSB  = 0;
  localparam int AVG_LSB   = 2;
  localparam int DRIFT_LSB = 5;
  localparam int TRIG_BIT  = 7;
  // axis_ctrl fields
  localparam int SEQ_LSB  = 0;
  localparam int DIR_BIT  = 4;
  localparam int BAND_LSB = 5;
  // conv_status fields
  localparam int RDY_BIT   = 0;
  localparam int DIAG_BIT  = 1;
  localparam int POR_BIT   = 4;
  localparam int COUNT_LSB = 5;
  // fault_flag_status fields
  localparam int FLT_SUPPLY   = 0;
  localparam int FLT_OTP      = 1;
  localparam int FLT_ALERT    = 2;
  localparam int FLT_CLOCK    = 3;
  localparam int FLT_READBACK = 4;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] AXIS_RESET = 8'h00;
  localparam logic [7:0] THR_RESET  = 8'h7F;

  localparam logic [1:0] MODE_TRIGGERED  = 2'h0;
  localparam logic [1:0] MODE_CONTINUOUS = 2'h2;
  localparam logic [3:0] SEQ_XZX         = 4'hB;
  localparam logic [1:0] CH_TEMP = 2'h0;
  localparam logic [1:0] CH_X    = 2'h1;
  localparam logic [1:0] CH_Y    = 2'h2;
  localparam logic [1:0] CH_Z    = 2'h3;
  localparam logic [2:0] AVG_MAX = 3'h5;          // 32 samples
  localparam logic [2:0] BAND_MIN_CODE = 3'h2;
  localparam logic [15:0] BAND_BASE = 16'h0080;    // 0.156 mT at 16-bit code, smallest range

  // thermal correction
  localparam logic [15:0] TEMP_REF    = 16'h4000;
  localparam logic [7:0]  SENSOR_COEF = 8'h04;
  localparam logic [7:0]  COEF_SEL1   = 8'h0C;
  localparam logic [7:0]  COEF_SEL2   = 8'h10;
  localparam logic [7:0]  COEF_SEL3   = 8'h14;
  localparam int GAIN_SHIFT = 8;
  localparam int ADJ_SHIFT  = 15;

  // timing
  localparam int CLK_PERIOD_NS   = 50;
  localparam int SPIN_TIME_NS    = 20000;
  localparam int ADC_TIME_NS     = 15000;
  localparam int ALERT_PULSE_NS  = 10000;
  localparam int ALERT_SETTLE_NS = 1000;
  localparam logic [8:0] SPIN_CYC   = 9'((SPIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0] ADC_CYC    = 9'((ADC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0] PULSE_CYC  = 9'((ALERT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0] SETTLE_CYC = 9'((ALERT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// *** hall_props.sv ***
// assertion checker on the ports of the hall sequencer, bound below
`timescale 1ns/1ns
`default_nettype none
module hall_props
  import hall_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_rdata,
  input wire logic        alert_out,
  input wire logic        alert_oe_n,
  input wire logic        spin_active,
  input wire logic [1:0]  spin_axis,
  input wire logic        adc_active,
  input wire logic [1:0]  adc_axis,
  input wire logic        supply_low_event,
  input wire logic        otp_crc_mismatch
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [9:0] adc_len_q;
  logic [9:0] low_len_q;
  // run lengths of the adc stage and of the alert pulse
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_len_q <= 10'h000;
      low_len_q <= 10'h000;
    end else begin
      adc_len_q <= adc_active ? adc_len_q + 10'h001 : 10'h000;
      low_len_q <= alert_oe_n ? 10'h000 : low_len_q + 10'h001;
    end
  end
  a_rdata_hold: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (reg_rd_en && reg_addr == 8'h1F |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_trigger_reads_zero: assert property (
    reg_rd_en && reg_addr == ADDR_CONV_CTRL |=> !reg_rdata[TRIG_BIT])
    else $error("trigger bit read back as one");
  a_temp_first: assert property ($rose(spin_active) |-> spin_axis == CH_TEMP)
    else $error("sequence did not start with temperature");
  a_adc_length: assert property ($fell(adc_active) |-> adc_len_q == {1'b0, ADC_CYC})
    else $error("adc stage length wrong");
  a_adc_from_spin: assert property (
    $rose(adc_active) |-> $past(spin_active) && adc_axis == $past(spin_axis))
    else $error("adc stage did not take the spun item");
  a_alert_pulse_len: assert property ($rose(alert_oe_n) |-> low_len_q == {1'b0, PULSE_CYC})
    else $error("alert pulse length wrong");
  a_alert_value_low: assert property (alert_out == 1'b0)
    else $error("open drain value not low");
  a_supply_flag_set: assert property (
    supply_low_event [*5] ##0 (reg_rd_en && reg_addr == ADDR_FAULT_STATUS)
    |=> reg_rdata[FLT_SUPPLY])
    else $error("supply low flag not set");
  a_otp_flag_set: assert property (
    otp_crc_mismatch [*5] ##0 (reg_rd_en && reg_addr == ADDR_FAULT_STATUS)
    |=> reg_rdata[FLT_OTP])
    else $error("checksum flag not set");
  a_diag_summary: assert property (
    supply_low_event [*5] ##0 (reg_rd_en && reg_addr == ADDR_CONV_STATUS)
    |=> reg_rdata[DIAG_BIT])
    else $error("summary diagnostic not set");
  c_adc_item: cover property ($rose(adc_active));
  c_alert: cover property ($fell(alert_oe_n));
  c_overlap: cover property (spin_active && adc_active);
endmodule
bind hall_conversion_and_fault_flags hall_props i_hall_props (
  .core_clk(core_clk), .rst_n(rst_n), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
  .spin_active(spin_active), .spin_axis(spin_axis), .adc_active(adc_active),
  .adc_axis(adc_axis), .supply_low_event(supply_low_event),
  .otp_crc_mismatch(otp_crc_mismatch)
);
`default_nettype wire

// *** hall_front_model.sv ***
// analog front end and pulled-up alert pin facing the hall sequencer
`timescale 1ns/1ns
`default_nettype none
module hall_front_model
  import hall_pkg::*;
(
  input  wire logic        adc_active,
  input  wire logic [1:0]  adc_axis,
  input  wire logic        alert_oe_n,
  input  wire logic        stuck_high,
  input  wire logic        pull_low,
  output logic      [15:0] adc_code,
  output logic             alert_pin
);
  logic [15:0] level;
  // fixed field per channel; temperature sits at the reference so correction is neutral
  assign level = (adc_axis == CH_TEMP) ? TEMP_REF : (adc_axis == CH_X) ? 16'h2000 :
                 (adc_axis == CH_Y) ? 16'h1000 : 16'hE000;
  // inverted outside a conversion so a late sample shows up as a wrong result
  assign adc_code  = adc_active ? level : ~level;
  // pull-up unless someone pulls low; stuck models a pin shorted high
  assign alert_pin = stuck_high | (alert_oe_n & ~pull_low);
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the hall sequencer: register tasks, limit table, modes, faults
`timescale 1ns/1ns
`default_nettype none
module testbench
  import hall_pkg::*;
;
  logic        core_clk   = 1'b0;
  logic        rst_n      = 1'b0;
  logic        reg_wr_en  = 1'b0;
  logic        reg_rd_en  = 1'b0;
  logic [7:0]  reg_addr   = 8'h00;
  logic [7:0]  reg_wdata  = 8'h00;
  logic [2:0]  flt_in     = 3'h0;
  logic        stuck_q    = 1'b0;
  logic        pull_q     = 1'b0;
  logic [7:0]  reg_rdata;
  logic        alert_out;
  logic        alert_oe_n;
  logic [15:0] adc_code;
  logic        spin_active;
  logic [1:0]  spin_axis;
  logic        adc_active;
  logic [1:0]  adc_axis;
  logic        alert_pin;
  int          err_count  = 0;
  int          n_tests    = 0;
  int          spin_rises = 0;
  int          alerts     = 0;
  logic        prev_adc   = 1'b0;
  logic        prev_spin  = 1'b0;
  logic        prev_oe    = 1'b1;
  int          overlap_n  = 0;
  logic [1:0]  axq[$];
  longint      tq[$];
  logic [7:0]  fmask [3]   = '{8'h01, 8'h02, 8'h08};
  logic [7:0]  lc_axis [8] = '{8'h01, 8'h11, 8'h51, 8'h41, 8'h71, 8'h51, 8'h05, 8'h04};
  logic [7:0]  lc_thr [8]  = '{8'h10, 8'h10, 8'h20, 8'h21, 8'h21, 8'h21, 8'h10, 8'h10};
  logic [7:0]  lc_hit [8]  = '{8'h01, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h01, 8'h00};
  logic [1:0]  ord [4]     = '{CH_TEMP, CH_X, CH_Z, CH_X};

  always #25 core_clk = ~core_clk;

  hall_conversion_and_fault_flags i_hall_conversion_and_fault_flags (
    .core_clk(core_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .alert_in(alert_pin), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
    .adc_code(adc_code), .spin_active(spin_active), .spin_axis(spin_axis),
    .adc_active(adc_active), .adc_axis(adc_axis), .supply_low_event(flt_in[0]),
    .otp_crc_mismatch(flt_in[1]), .clock_fault(flt_in[2])
  );
  hall_front_model i_hall_front_model (
    .adc_active(adc_active), .adc_axis(adc_axis), .alert_oe_n(alert_oe_n),
    .stuck_high(stuck_q), .pull_low(pull_q), .adc_code(adc_code), .alert_pin(alert_pin)
  );

  // stage monitor on the falling edge, clear of the design's own updates
  always @(negedge core_clk) begin
    if (adc_active && !prev_adc) axq.push_back(adc_axis);
    if (!adc_active && prev_adc) tq.push_back($time);
    if (spin_active && !prev_spin) spin_rises++;
    if (!alert_oe_n && prev_oe) alerts++;
    if (spin_active && adc_active) overlap_n++;
    prev_adc = adc_active;
    prev_spin = spin_active;
    prev_oe = alert_oe_n;
  end

  task automatic test_done();
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic fail_to();
    err_count++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    test_done();
  endtask
  // one-cycle strobes, raised and dropped on rising edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask
  task automatic wait_ready();
    logic [7:0] d;
    d = 8'h00;
    for (int k = 0; k < 9000 && d[RDY_BIT] !== 1'b1; k++) rd(ADDR_CONV_STATUS, d);
    if (d[RDY_BIT] !== 1'b1) fail_to();
  endtask

  initial begin
    int base;
    int obase;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rchk(ADDR_FAULT_STATUS, 8'h10);
    rchk(ADDR_CONV_STATUS, 8'h10);
    wr(ADDR_CONV_STATUS, 8'h10);
    rchk(ADDR_CONV_STATUS, 8'h00);
    rchk(8'h1F, 8'h00);
    // each fault input latches, survives a zero write, clears on a one
    for (int i = 0; i < 3; i++) begin
      flt_in <= 3'(1 << i);
      repeat (6) @(posedge core_clk);
      rchk(ADDR_FAULT_STATUS, 8'h10 | fmask[i]);
      rchk(ADDR_CONV_STATUS, 8'h02);
      flt_in <= 3'h0;
      wr(ADDR_FAULT_STATUS, 8'h00);
      rchk(ADDR_FAULT_STATUS, 8'h10 | fmask[i]);
      wr(ADDR_FAULT_STATUS, fmask[i]);
      rchk(ADDR_FAULT_STATUS, 8'h10);
      rchk(ADDR_CONV_STATUS, 8'h00);
    end
    base = spin_rises;
    repeat (500) @(posedge core_clk);
    check(8'(spin_rises - base), 8'h00);
    // limit table: above, below, band inside and outside, band doubling, several axes
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_AXIS_CTRL, lc_axis[i]);
      wr(ADDR_LIMIT_THR, lc_thr[i]);
      base = alerts;
      wr(ADDR_CONV_CTRL, 8'h80);
      wait_ready();
      repeat (4) @(posedge core_clk);
      check(8'(alerts - base), lc_hit[i]);
    end
    rchk(ADDR_CONV_STATUS, 8'h01);
    rchk(ADDR_X_MSB, 8'h20);
    rchk(ADDR_TEMP_MSB, TEMP_REF[15:8]);
    base = spin_rises;
    pull_q <= 1'b1;
    for (int k = 0; k < 20 && spin_rises == base; k++) @(posedge core_clk);
    check(8'(spin_rises - base), 8'h01);
    pull_q <= 1'b0;
    wait_ready();
    // a pin that stays high while driven low is a pin fault
    wr(ADDR_AXIS_CTRL, 8'h01);
    stuck_q <= 1'b1;
    wr(ADDR_CONV_CTRL, 8'h80);
    wait_ready();
    repeat (40) @(posedge core_clk);
    rchk(ADDR_FAULT_STATUS, 8'h14);
    rchk(ADDR_CONV_STATUS, 8'h43);
    stuck_q <= 1'b0;
    // let our pulse end so the readback is high again and no new pin fault races the clear
    repeat (PULSE_CYC) @(posedge core_clk);
    wr(ADDR_FAULT_STATUS, 8'h04);
    rchk(ADDR_FAULT_STATUS, 8'h10);
    // continuous x-z-x: order, spacing, overlap and repeated alerts
    wr(ADDR_AXIS_CTRL, 8'h0B);
    axq.delete();
    tq.delete();
    base = alerts;
    obase = overlap_n;
    wr(ADDR_CONV_CTRL, 8'h02);
    for (int k = 0; k < 8000 && axq.size() < 9; k++) @(posedge core_clk);
    if (axq.size() < 9) fail_to();
    check(8'(alerts - base), 8'h02);
    for (int k = 0; k < 9; k++) check({6'h00, axq[k]}, {6'h00, ord[k % 4]});
    check(8'(tq[3] - tq[2] == tq[2] - tq[1]), 8'h01);
    check({7'h00, overlap_n > obase}, 8'h01);
    wr(ADDR_CONV_CTRL, 8'h01);
    wait_ready();
    rchk(ADDR_X_MSB, 8'h20);
    rchk(ADDR_Z_MSB, 8'hE0);
    // averaging code above the top clamps to 32 samples of x
    wr(ADDR_AXIS_CTRL, 8'h01);
    wr(ADDR_LIMIT_THR, 8'h7F);
    axq.delete();
    // mode and averaging must already stand when the trigger write arrives
    wr(ADDR_CONV_CTRL, 8'h1C);
    wr(ADDR_CONV_CTRL, 8'h9C);
    wait_ready();
    check(8'(axq.size()), 8'd33);
    rchk(ADDR_X_MSB, 8'h20);
    test_done();
  end
endmodule
`default_nettype wire
